// >>> hdl/gpp_port.v
// eight-pin port: output data, pin state, edge interrupts, routing
`timescale 1ns/1ps
`include "gpp_defines.vh"
module gpp_port #(
    parameter [2:0] PORT_NUM = 3'h0
) (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire [3:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    input  wire [7:0]  pin_in_i,
    output reg  [7:0]  pin_out_o,
    output reg  [7:0]  pin_oe_o,
    input  wire [7:0]  ic_out_i,
    input  wire [7:0]  ic_oe_i,
    input  wire        mux_level_mode_i,
    output reg         port_irq_o,
    output reg  [4:0]  irq_line_o,
    output reg  [7:0]  amux_a_en_o,
    output reg  [7:0]  amux_b_en_o,
    output reg  [7:0]  in_buf_en_o
);
    // port has interconnect adapter
    localparam HAS_ADAPTER = (PORT_NUM < 3'h4);
    localparam IRQ_CAPABLE = (PORT_NUM != 3'h6);

    reg  [7:0]  out_value_q;
    reg  [23:0] drive_cfg_q;
    reg  [31:0] irq_config_q;
    reg  [31:0] route_sel_q;
    reg  [9:0]  serial_ctrl_q;
    reg  [7:0]  sync_q;
    reg  [7:0]  pin_lvl;
    wire [8:0]  flags;
    wire        flt_out;
    wire [8:0]  clr;
    reg  [2:0]  filter_pin_select;
    reg         any_q;
    reg  [7:0]  ser_kill;
    reg  [7:0]  out_d;
    reg  [7:0]  oe_d;
    reg  [3:0]  route;
    integer     i;
    integer     j;

    // sync only where the adapter exists
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sync_q <= 8'h00;
        else
            sync_q <= pin_in_i;
    end

    always @*
    begin
        pin_lvl = HAS_ADAPTER ? sync_q : pin_in_i;
        filter_pin_select = irq_config_q[`GPP_FILTER_PIN_SELECT_LSB +: 3];
    end

    // write one to status clears flags
    assign clr = (wr_i && addr_i == `GPP_OFS_IRQ_STATUS) ? wdata_i[8:0] : 9'h000;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_pin
            gpp_edge_det u_det (
                .clk_i      (clk_i),
                .rst_n_i    (rst_n_i),
                .level_i    (pin_lvl[g]),
                .edge_sel_i (IRQ_CAPABLE ? irq_config_q[2*g +: 2] : `GPP_EDGE_OFF),
                .clear_i    (clr[g]),
                .flag_o     (flags[g])
            );
        end
    endgenerate

    gpp_glitch_filter u_flt (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .in_i    (pin_lvl[filter_pin_select]),
        .out_o   (flt_out)
    );

    gpp_edge_det u_flt_det (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .level_i    (flt_out),
        .edge_sel_i (IRQ_CAPABLE ? irq_config_q[`GPP_FLT_EDGE_LSB +: 2] : `GPP_EDGE_OFF),
        .clear_i    (clr[`GPP_STAT_FLT_BIT]),
        .flag_o     (flags[`GPP_STAT_FLT_BIT])
    );

    // register writes
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            out_value_q   <= 8'h00;
            drive_cfg_q   <= 24'h000000;
            irq_config_q  <= 32'h00000000;
            route_sel_q   <= 32'h00000000;
            serial_ctrl_q <= 10'h000;
        end
        else if (wr_i)
        begin
            case (addr_i)
                `GPP_OFS_OUT_VALUE:   out_value_q   <= wdata_i[7:0];
                `GPP_OFS_OUT_SET:     out_value_q   <= out_value_q | wdata_i[7:0];
                `GPP_OFS_OUT_CLEAR:   out_value_q   <= out_value_q & ~wdata_i[7:0];
                `GPP_OFS_OUT_INVERT:  out_value_q   <= out_value_q ^ wdata_i[7:0];
                `GPP_OFS_DRIVE_CFG:   drive_cfg_q   <= wdata_i[23:0];
                `GPP_OFS_IRQ_CONFIG:  irq_config_q  <= {3'h0, wdata_i[28:24], 2'h0, wdata_i[21:20], 1'b0,
                                                        wdata_i[18:0]};
                `GPP_OFS_ROUTE_SEL:   route_sel_q   <= wdata_i;
                `GPP_OFS_SERIAL_CTRL: serial_ctrl_q <= wdata_i[9:0];
                default: ;
            endcase
        end
    end

    // register reads, data in following cycle
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= 32'h00000000;
        else if (rd_i)
        begin
            case (addr_i)
                `GPP_OFS_OUT_VALUE:   rdata_o <= {24'h000000, out_value_q};
                `GPP_OFS_PIN_STATE:   rdata_o <= {24'h000000, pin_lvl};
                `GPP_OFS_DRIVE_CFG:   rdata_o <= {8'h00, drive_cfg_q};
                `GPP_OFS_IRQ_CONFIG:  rdata_o <= irq_config_q;
                // flags and levels in one word
                `GPP_OFS_IRQ_STATUS:  rdata_o <= {7'h00, flt_out, pin_lvl, 7'h00, flags};
                `GPP_OFS_ROUTE_SEL:   rdata_o <= route_sel_q;
                `GPP_OFS_SERIAL_CTRL: rdata_o <= {22'h0, serial_ctrl_q};
                default:              rdata_o <= 32'h00000000;
            endcase
        end
        else
            rdata_o <= 32'h00000000;
    end

    // pin drive, serial override and analog routing
    always @*
    begin
        ser_kill = 8'h00;
        // serial block forces output buffer off
        case (serial_ctrl_q[1:0])
            `GPP_SER_UART:       ser_kill[serial_ctrl_q[4:2]] = 1'b1;
            `GPP_SER_SPI_MASTER: ser_kill[serial_ctrl_q[7:5]] = 1'b1;
            `GPP_SER_SPI_SLAVE:
            begin
                ser_kill[serial_ctrl_q[4:2]] = 1'b1;
                ser_kill[serial_ctrl_q[7:5]] = 1'b1;
            end
            default: ser_kill = 8'h00;
        endcase
        for (i = 0; i < 8; i = i + 1)
        begin
            route    = route_sel_q[4*i +: 4];
            out_d[i] = out_value_q[i];
            oe_d[i]  = drive_cfg_q[3*i +: 3] != `GPP_DRIVE_HIZ;
            if (HAS_ADAPTER)
            begin
                case (route)
                    `GPP_ROUTE_FW_DSI:  oe_d[i] = ic_oe_i[i];
                    `GPP_ROUTE_DSI_DSI:
                    begin
                        out_d[i] = ic_out_i[i];
                        oe_d[i]  = ic_oe_i[i];
                    end
                    `GPP_ROUTE_DSI_FW:  out_d[i] = ic_out_i[i];
                    default:            out_d[i] = out_value_q[i];
                endcase
            end
            if (ser_kill[i])
                oe_d[i] = 1'b0;
        end
    end

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pin_out_o   <= 8'h00;
            pin_oe_o    <= 8'h00;
            amux_a_en_o <= 8'h00;
            amux_b_en_o <= 8'h00;
            in_buf_en_o <= 8'h00;
            any_q       <= 1'b0;
            port_irq_o  <= 1'b0;
            irq_line_o  <= 5'h00;
        end
        else
        begin
            pin_out_o <= out_d;
            pin_oe_o  <= oe_d;
            for (j = 0; j < 8; j = j + 1)
            begin
                // analog bus needs both interconnect signals on ports with the adapter
                amux_a_en_o[j] <= (route_sel_q[4*j +: 4] == `GPP_ROUTE_AMUX_A) &&
                                  (!HAS_ADAPTER || (ic_out_i[j] && ic_oe_i[j]));
                amux_b_en_o[j] <= (route_sel_q[4*j +: 4] == `GPP_ROUTE_AMUX_B) &&
                                  (!HAS_ADAPTER || (ic_out_i[j] && ic_oe_i[j]));
                in_buf_en_o[j] <= drive_cfg_q[3*j +: 3] != `GPP_DRIVE_HIZ;
            end
            any_q <= |flags;
            // level mode follows flags; rising mode pulses once
            port_irq_o <= mux_level_mode_i ? (|flags) : ((|flags) & ~any_q);
            // interconnect route picks any of 32 lines
            irq_line_o <= HAS_ADAPTER ? serial_ctrl_q[9:8] == 2'h0 ? {2'h0, PORT_NUM} : irq_config_q[28:24]
                                      : {2'h0, PORT_NUM};
        end
    end
endmodule // gpp_port

// >>> hdl/gpp_defines.vh
// constants for the eight-pin port block
`ifndef GPP_DEFINES_VH
`define GPP_DEFINES_VH
`define GPP_ADDR_W          4
`define GPP_OFS_OUT_VALUE   4'h0
`define GPP_OFS_OUT_SET     4'h1
`define GPP_OFS_OUT_CLEAR   4'h2
`define GPP_OFS_OUT_INVERT  4'h3
`define GPP_OFS_PIN_STATE   4'h4
`define GPP_OFS_DRIVE_CFG   4'h5
`define GPP_OFS_IRQ_CONFIG  4'h6
`define GPP_OFS_IRQ_STATUS  4'h7
`define GPP_OFS_ROUTE_SEL   4'h8
`define GPP_OFS_SERIAL_CTRL 4'h9
`define GPP_EDGE_OFF        2'h0
`define GPP_EDGE_RISE       2'h1
`define GPP_EDGE_FALL       2'h2
`define GPP_EDGE_BOTH       2'h3
`define GPP_FILTER_PIN_SELECT_LSB     16
`define GPP_FLT_EDGE_LSB    20
`define GPP_STAT_FLT_BIT    8
`define GPP_STAT_LVL_LSB    16
`define GPP_STAT_FLT_LVL    24
`define GPP_ROUTE_AMUX_A    4'h6
`define GPP_ROUTE_AMUX_B    4'h7
`define GPP_ROUTE_FW_DSI    4'h1
`define GPP_ROUTE_DSI_DSI   4'h2
`define GPP_ROUTE_DSI_FW    4'h3
`define GPP_SER_OFF         2'h0
`define GPP_SER_UART        2'h1
`define GPP_SER_SPI_MASTER  2'h2
`define GPP_SER_SPI_SLAVE   2'h3
`define GPP_PIN_RX          3'h0
`define GPP_PIN_MISO        3'h1
`define GPP_PIN_MOSI        3'h2
`define GPP_PIN_SEL         3'h3
`define GPP_DRIVE_HIZ       3'h0
`define GPP_FLT_STABLE      2'h3
`endif

// >>> hdl/gpp_edge_det.v
// per-channel edge detector with sticky flag
`timescale 1ns/1ps
`include "gpp_defines.vh"
module gpp_edge_det (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire       level_i,
    input  wire [1:0] edge_sel_i,
    input  wire       clear_i,
    output reg        flag_o
);
    reg  level_q;
    wire rise;
    wire fall;
    reg  hit;

    assign rise = level_i & ~level_q;
    assign fall = ~level_i & level_q;

    always @*
    begin
        case (edge_sel_i)
            `GPP_EDGE_RISE: hit = rise;
            `GPP_EDGE_FALL: hit = fall;
            `GPP_EDGE_BOTH: hit = rise | fall;
            default:        hit = 1'b0;
        endcase
    end

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            level_q <= 1'b0;
            flag_o  <= 1'b0;
        end
        else
        begin
            level_q <= level_i;
            if (hit)
                flag_o <= 1'b1;
            else if (clear_i)
                flag_o <= 1'b0;
        end
    end
endmodule // gpp_edge_det

// >>> hdl/gpp_glitch_filter.v
// glitch filter: output follows input after stable run
`timescale 1ns/1ps
`include "gpp_defines.vh"
module gpp_glitch_filter #(
    parameter [1:0] STABLE_CYCLES = `GPP_FLT_STABLE
) (
    input  wire clk_i,
    input  wire rst_n_i,
    input  wire in_i,
    output reg  out_o
);
    reg [1:0] cnt_q;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= 2'h0;
            out_o <= 1'b0;
        end
        else if (in_i == out_o)
            cnt_q <= 2'h0;
        else if (cnt_q == STABLE_CYCLES - 2'h1)
        begin
            cnt_q <= 2'h0;
            out_o <= in_i;
        end
        else
            cnt_q <= cnt_q + 2'h1;
    end
endmodule // gpp_glitch_filter

// >>> sim/gpp_port_sva.sv
// concurrent checks on the port block pins and bus
`timescale 1ns/1ps
`include "gpp_defines.vh"
module gpp_port_chk (
    input wire        clk_i,
    input wire        rst_n_i,
    input wire [3:0]  addr_i,
    input wire [31:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [31:0] rdata_o,
    input wire [7:0]  pin_out_o,
    input wire [7:0]  ic_out_i,
    input wire [7:0]  ic_oe_i,
    input wire        mux_level_mode_i,
    input wire        port_irq_o,
    input wire [7:0]  amux_a_en_o,
    input wire [7:0]  amux_b_en_o
);
    reg       clr_q;
    reg [7:0] g1_q;
    reg [7:0] g2_q;
    reg [7:0] g3_q;
    // status write seen, gate history
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            clr_q <= 1'b0;
            g1_q  <= 8'h00;
            g2_q  <= 8'h00;
            g3_q  <= 8'h00;
        end
        else
        begin
            clr_q <= wr_i && (addr_i == `GPP_OFS_IRQ_STATUS);
            g1_q  <= ic_out_i & ic_oe_i;
            g2_q  <= g1_q;
            g3_q  <= g2_q;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_out_write: assert property (wr_i && addr_i == `GPP_OFS_OUT_VALUE |->
        ##2 pin_out_o == $past(wdata_i[7:0], 2)) else $error("output value write not applied");
    a_out_set: assert property (wr_i && addr_i == `GPP_OFS_OUT_SET |->
        ##2 (pin_out_o & $past(wdata_i[7:0], 2)) == $past(wdata_i[7:0], 2)) else $error("set write left a bit low");
    a_out_clear: assert property (wr_i && addr_i == `GPP_OFS_OUT_CLEAR |->
        ##2 (pin_out_o & $past(wdata_i[7:0], 2)) == 8'h00) else $error("clear write left a bit high");
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside its cycle");
    a_irq_drop: assert property ($fell(port_irq_o) && mux_level_mode_i && $past(mux_level_mode_i) |->
        clr_q || $past(clr_q) || $past(clr_q, 2)) else $error("level interrupt fell without clear");
    a_irq_pulse: assert property ((!mux_level_mode_i && port_irq_o) ##1 !mux_level_mode_i |-> !port_irq_o)
        else $error("rising mode interrupt longer than one cycle");
    a_amux_gate: assert property (((amux_a_en_o | amux_b_en_o) & ~(g1_q | g2_q | g3_q)) == 8'h00)
        else $error("analog bus joined without both gate signals");
    a_amux_excl: assert property ((amux_a_en_o & amux_b_en_o) == 8'h00)
        else $error("pin on both analog buses");
    c_level_irq: cover property (mux_level_mode_i && $rose(port_irq_o));
    c_pulse_irq: cover property (!mux_level_mode_i && port_irq_o);
    c_amux_on: cover property (amux_a_en_o != 8'h00);
endmodule // gpp_port_chk

bind gpp_port gpp_port_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_out_o(pin_out_o), .ic_out_i(ic_out_i), .ic_oe_i(ic_oe_i),
    .mux_level_mode_i(mux_level_mode_i), .port_irq_o(port_irq_o), .amux_a_en_o(amux_a_en_o),
    .amux_b_en_o(amux_b_en_o));

// >>> sim/gpp_pad_model.sv
// external circuit on the eight pins
`timescale 1ns/1ps
module gpp_pad_model (
    input  wire [7:0] ext_i,
    input  wire [7:0] pin_out_i,
    input  wire [7:0] pin_oe_i,
    output wire [7:0] level_o
);
    // driven pins show the port value, others the outside level
    assign level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_i);
endmodule // gpp_pad_model

// >>> sim/gpp_port_tb_top.sv
// self-checking bench for the eight-pin port block
`timescale 1ns/1ps
`include "gpp_defines.vh"
module gpp_port_tb_top;
    reg         clk_i = 1'b0;
    reg         rst_n_i = 1'b0;
    reg  [3:0]  addr = 4'h0;
    reg  [31:0] wdata = 32'h0;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg         mux = 1'b1;
    reg  [7:0]  ext = 8'h00;
    reg  [7:0]  ic_out = 8'h00;
    reg  [7:0]  ic_oe = 8'h00;
    wire [31:0] rdata;
    wire [7:0]  pin_out, pin_oe, pin_lvl, amux_a, amux_b;
    wire        irq;
    wire [4:0]  irq_line;
    wire [7:0]  in_buf;
    integer     bad_count = 0;
    integer     n_checks = 0;
    integer     pulses = 0;
    integer     i, c0;
    reg  [31:0] s;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i)
        if (irq === 1'b1)
            pulses <= pulses + 1;
    gpp_pad_model pads (.ext_i(ext), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .level_o(pin_lvl));
    gpp_port dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .ic_out_i(ic_out),
        .ic_oe_i(ic_oe), .mux_level_mode_i(mux), .port_irq_o(irq), .irq_line_o(irq_line), .amux_a_en_o(amux_a),
        .amux_b_en_o(amux_b), .in_buf_en_o(in_buf));
    task wait_n(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    task bw(input [3:0] a, input [31:0] d);
    begin
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_i) wr <= 1'b0;
        wait_n(2);
    end
    endtask
    task br(input [3:0] a);
    begin
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i) rd <= 1'b0;
        @(posedge clk_i) s = rdata;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task complete_run;
    begin
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task t_out;
    begin
        bw(`GPP_OFS_OUT_VALUE, 32'ha5);
        br(`GPP_OFS_OUT_VALUE);
        chk(s, 32'ha5);
        chk({24'h0, pin_out}, 32'ha5);
        bw(`GPP_OFS_OUT_SET, 32'h0f);
        bw(`GPP_OFS_OUT_CLEAR, 32'ha0);
        bw(`GPP_OFS_OUT_INVERT, 32'h3c);
        br(`GPP_OFS_OUT_VALUE);
        chk(s, 32'h33);
    end
    endtask
    task t_pins;
    begin
        bw(`GPP_OFS_DRIVE_CFG, 32'h0);
        ext <= 8'h3c;
        wait_n(6);
        br(`GPP_OFS_PIN_STATE);
        chk(s, 32'h3c);
        bw(`GPP_OFS_PIN_STATE, 32'hff);
        br(`GPP_OFS_PIN_STATE);
        chk(s, 32'h3c);
        br(4'hf);
        chk(s, 32'h0);
        br(`GPP_OFS_IRQ_STATUS);
        chk(s & 32'h00ff01ff, 32'h003c0000);
    end
    endtask
    task t_edge(input [1:0] m);
    begin
        ext <= 8'h00;
        bw(`GPP_OFS_IRQ_CONFIG, {16'h0, {8{m}}});
        bw(`GPP_OFS_IRQ_STATUS, 32'h1ff);
        ext <= 8'hff;
        wait_n(6);
        chk({31'h0, irq}, {31'h0, m[0]});
        br(`GPP_OFS_IRQ_STATUS);
        chk(s & 32'h1ff, m[0] ? 32'hff : 32'h0);
        bw(`GPP_OFS_IRQ_STATUS, 32'h0ff);
        wait_n(2);
        chk({31'h0, irq}, 32'h0);
        ext <= 8'h00;
        wait_n(6);
        br(`GPP_OFS_IRQ_STATUS);
        chk(s & 32'h1ff, m[1] ? 32'hff : 32'h0);
        bw(`GPP_OFS_IRQ_STATUS, 32'h1ff);
    end
    endtask
    task t_filter;
    begin
        bw(`GPP_OFS_IRQ_CONFIG, 32'h00150000);
        bw(`GPP_OFS_IRQ_STATUS, 32'h1ff);
        ext <= 8'h20;
        @(posedge clk_i) ext <= 8'h00;
        wait_n(10);
        br(`GPP_OFS_IRQ_STATUS);
        chk(s & 32'h010001ff, 32'h0);
        ext <= 8'h20;
        wait_n(10);
        br(`GPP_OFS_IRQ_STATUS);
        chk(s & 32'h010001ff, 32'h01000100);
        chk({31'h0, irq}, 32'h1);
        bw(`GPP_OFS_IRQ_STATUS, 32'h100);
    end
    endtask
    task t_rise;
    begin
        mux <= 1'b0;
        bw(`GPP_OFS_IRQ_CONFIG, 32'h5555);
        bw(`GPP_OFS_IRQ_STATUS, 32'h1ff);
        c0 = pulses;
        ext <= 8'h01;
        wait_n(6);
        ext <= 8'h03;
        wait_n(6);
        chk(pulses - c0, 32'h1);
        bw(`GPP_OFS_IRQ_STATUS, 32'h1ff);
        ext <= 8'h07;
        wait_n(6);
        chk(pulses - c0, 32'h2);
        bw(`GPP_OFS_IRQ_STATUS, 32'h1ff);
        mux <= 1'b1;
    end
    endtask
    task t_route;
    begin
        bw(`GPP_OFS_DRIVE_CFG, 32'h0);
        bw(`GPP_OFS_ROUTE_SEL, 32'h76);
        chk({16'h0, pin_oe, in_buf}, 32'h0);
        ic_out <= 8'h03;
        wait_n(4);
        chk({16'h0, amux_b, amux_a}, 32'h0);
        ic_oe <= 8'h03;
        wait_n(4);
        chk({16'h0, amux_b, amux_a}, 32'h0201);
        bw(`GPP_OFS_DRIVE_CFG, 32'h00db6db6);
        chk({24'h0, in_buf}, 32'hff);
        bw(`GPP_OFS_SERIAL_CTRL, 32'h9);
        chk({31'h0, pin_oe[2]}, 32'h0);
        bw(`GPP_OFS_SERIAL_CTRL, 32'h8f);
        chk({30'h0, pin_oe[4], pin_oe[3]}, 32'h0);
        chk({27'h0, irq_line}, 32'h0);
        bw(`GPP_OFS_IRQ_CONFIG, 32'h15000000);
        bw(`GPP_OFS_SERIAL_CTRL, 32'h30f);
        chk({27'h0, irq_line}, 32'h15);
    end
    endtask
    initial
    begin
        wait_n(10);
        rst_n_i <= 1'b1;
        t_out;
        t_pins;
        for (i = 0; i < 4; i = i + 1)
            t_edge(i[1:0]);
        t_filter;
        t_rise;
        t_route;
        complete_run;
    end
    initial
    begin
        #20000;
        bad_count = bad_count + 1;
        complete_run;
    end
endmodule // gpp_port_tb_top
